// >>> common/fip_pkg.sv
// shared constants and carrier types for the flash programming controller
package fip_pkg;
    // register indices on the software port
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_BUF_CTRL = 4'h1;
    localparam logic [3:0] REG_ADDR_LO = 4'h2;
    localparam logic [3:0] REG_ADDR_HI = 4'h3;
    localparam logic [3:0] REG_WORD_LO = 4'h4;
    localparam logic [3:0] REG_WORD_HI = 4'h5;
    localparam logic [3:0] REG_PAT_LO1 = 4'h6;
    localparam logic [3:0] REG_PAT_LO2 = 4'h7;
    localparam logic [3:0] REG_PAT_LO3 = 4'h8;
    localparam logic [3:0] REG_PAT_HI1 = 4'h9;
    localparam logic [3:0] REG_PAT_HI2 = 4'hA;
    localparam logic [3:0] REG_PAT_HI3 = 4'hB;
    // control register field positions
    localparam int CTRL_ENABLED_BIT = 7;
    localparam int CTRL_MODE_MSB = 6;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_TRIGGER_BIT = 3;
    localparam int CTRL_WRITE_BIT = 2;
    localparam int CTRL_RDEN_BIT = 1;
    localparam int CTRL_READ_BIT = 0;
    localparam int BUF_CLEAR_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // operation select codes
    localparam logic [2:0] MODE_WRITE = 3'h0;
    localparam logic [2:0] MODE_ERASE = 3'h1;
    localparam logic [2:0] MODE_READ = 3'h3;
    localparam logic [2:0] MODE_UNLOCK = 3'h6;
    // unlock pattern: low bytes 1..3 then high bytes 1..3
    localparam logic [7:0] PAT_LO1 = 8'h00;
    localparam logic [7:0] PAT_LO2 = 8'h0D;
    localparam logic [7:0] PAT_LO3 = 8'hC3;
    localparam logic [7:0] PAT_HI1 = 8'h04;
    localparam logic [7:0] PAT_HI2 = 8'h09;
    localparam logic [7:0] PAT_HI3 = 8'h40;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROG_TIME_NS = 2200000;
    localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int UNLOCK_TIME_NS = 10000;
    localparam int UNLOCK_CYCLES = UNLOCK_TIME_NS / CLK_PERIOD_NS;
    localparam int READ_INSTR_CYCLES = 3;
    localparam int READ_CYCLES = READ_INSTR_CYCLES;
    localparam int PAGE_WORDS = 32;
    localparam int ADDR_W = 13;

    typedef enum logic [2:0] {
        FIP_IDLE = 3'b000,
        FIP_PROG = 3'b001,
        FIP_WAIT = 3'b010,
        FIP_READ = 3'b011
    } fip_state_t;

    // request towards the flash array
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [15:0] wdata;
        logic we;
        logic erase;
        logic re;
    } fip_req_t;
endpackage

// >>> rtl/fip_ctrl.sv
// in-application flash page erase, page program and word read controller
`timescale 1ns/1ns

// Behaviour
// - write buffer holds 32 words, one flash page per write.
// - high byte write stores the word and advances the buffer address by one.
// - buffer address stops at the last page location, never wraps.
// - mode 001 selects page erase.
// - mode 000 selects page write from the buffer.
// - erase start erases the whole addressed page.
// - write start programs only the loaded buffer slots into the addressed page.
// - write-initiate clears itself when erase or write finishes, about 2.2 ms.
// - CPU is halted while erase or write runs.
// - erase and write only run once erase/write is enabled.
// - buffer clear then rewrite of the same page without erase is accepted.
// - clearing the enabled flag blocks further erase and write, except inside a live unlock window that holds the correct pattern.
// - mode 011 with read enable set selects read mode.
// - read start fetches the addressed word into the data pair, then clears.
// - read halts the CPU and read-initiate drops after three cycles.
// - reads do not need erase/write to be enabled.
// - mode 110 plus trigger starts a timer; pattern must land before timeout.
// - correct unlock pattern sets the enabled flag, wrong one leaves it clear.
// - buffer clear bit empties the buffer and clears itself when done.
module fip_ctrl
    import fip_pkg::*;
#(
    parameter int PROG_CYCLES_P = PROG_CYCLES
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [15:0] flash_rdata_i,
    output fip_req_t flash_req_o,
    output logic cpu_halt_o
);
    localparam int CNT_W = $clog2(PROG_CYCLES_P + 1);
    localparam logic [CNT_W-1:0] OP_LOAD = CNT_W'(PROG_CYCLES_P - 1);
    localparam logic [CNT_W-1:0] RD_LOAD = CNT_W'(READ_CYCLES - 1);
    localparam logic [CNT_W-1:0] RD_CAPTURE = CNT_W'(READ_CYCLES - 2);
    localparam logic [4:0] LAST_SLOT = 5'(PAGE_WORDS - 1);
    localparam int UNL_W = $clog2(UNLOCK_CYCLES + 1);

    logic [7:0] ctrl;
    logic buf_clear;
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] word_lo;
    logic [7:0] word_hi;
    logic [7:0] pat [6];
    logic [15:0] buf_mem [PAGE_WORDS];
    logic [PAGE_WORDS-1:0] buf_valid;
    logic [4:0] buf_ptr;
    logic [UNL_W-1:0] unl_cnt;
    fip_state_t state;
    fip_state_t next_state;
    logic [CNT_W-1:0] op_cnt;
    logic [CNT_W-1:0] next_op_cnt;
    logic [4:0] prog_idx;
    logic [4:0] next_prog_idx;
    logic done_write;
    logic done_read;
    logic start_erase;
    logic start_read;
    logic pattern_ok;
    logic [ADDR_W-1:0] full_addr;
    logic [2:0] mode;

    assign mode = ctrl[CTRL_MODE_MSB:CTRL_MODE_LSB];
    assign full_addr = ADDR_W'({addr_hi, addr_lo});
    assign pattern_ok = (pat[0] == PAT_LO1) && (pat[1] == PAT_LO2) && (pat[2] == PAT_LO3)
        && (pat[3] == PAT_HI1) && (pat[4] == PAT_HI2) && (pat[5] == PAT_HI3);

    wire wr_ctrl = reg_wr_i && (reg_addr_i == REG_CTRL);
    wire wr_buf_ctrl = reg_wr_i && (reg_addr_i == REG_BUF_CTRL);
    wire wr_word_hi = reg_wr_i && (reg_addr_i == REG_WORD_HI);
    wire unlock_live = ctrl[CTRL_TRIGGER_BIT];
    wire unlock_hit = unlock_live && pattern_ok;

    // sequencer: one op at a time, selected from the latched control bits
    always_comb
    begin
        next_state = state;
        next_op_cnt = op_cnt;
        next_prog_idx = prog_idx;
        done_write = 1'b0;
        done_read = 1'b0;
        start_erase = 1'b0;
        start_read = 1'b0;
        unique case (state)
            FIP_IDLE:
            begin
                if (ctrl[CTRL_WRITE_BIT])
                begin
                    if (ctrl[CTRL_ENABLED_BIT] && (mode == MODE_ERASE))
                    begin
                        start_erase = 1'b1;
                        next_op_cnt = OP_LOAD;
                        next_state = FIP_WAIT;
                    end
                    else if (ctrl[CTRL_ENABLED_BIT] && (mode == MODE_WRITE))
                    begin
                        next_op_cnt = OP_LOAD;
                        next_prog_idx = 5'h00;
                        next_state = FIP_PROG;
                    end
                    else
                    begin
                        done_write = 1'b1;
                    end
                end
                else if (ctrl[CTRL_READ_BIT])
                begin
                    if (ctrl[CTRL_RDEN_BIT] && (mode == MODE_READ))
                    begin
                        start_read = 1'b1;
                        next_op_cnt = RD_LOAD;
                        next_state = FIP_READ;
                    end
                    else
                    begin
                        done_read = 1'b1;
                    end
                end
            end
            FIP_PROG:
            begin
                next_op_cnt = op_cnt - CNT_W'(1);
                next_prog_idx = prog_idx + 5'h01;
                if (prog_idx == LAST_SLOT)
                begin
                    next_state = FIP_WAIT;
                end
            end
            FIP_WAIT:
            begin
                next_op_cnt = op_cnt - CNT_W'(1);
                if (op_cnt == '0)
                begin
                    done_write = 1'b1;
                    next_state = FIP_IDLE;
                end
            end
            FIP_READ:
            begin
                next_op_cnt = op_cnt - CNT_W'(1);
                if (op_cnt == '0)
                begin
                    done_read = 1'b1;
                    next_state = FIP_IDLE;
                end
            end
            default:
            begin
                next_state = FIP_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state <= FIP_IDLE;
            op_cnt <= '0;
            prog_idx <= 5'h00;
            cpu_halt_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            op_cnt <= next_op_cnt;
            prog_idx <= next_prog_idx;
            cpu_halt_o <= (next_state != FIP_IDLE);
        end
    end

    // flash array requests; the whole page is swept, only loaded slots are programmed
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            flash_req_o <= '0;
        end
        else
        begin
            flash_req_o.we <= 1'b0;
            flash_req_o.erase <= 1'b0;
            flash_req_o.re <= 1'b0;
            if (start_erase)
            begin
                flash_req_o.erase <= 1'b1;
                flash_req_o.addr <= {full_addr[ADDR_W-1:5], 5'h00};
            end
            else if (state == FIP_PROG)
            begin
                flash_req_o.we <= buf_valid[prog_idx];
                flash_req_o.addr <= {full_addr[ADDR_W-1:5], prog_idx};
                flash_req_o.wdata <= buf_mem[prog_idx];
            end
            else if (start_read)
            begin
                flash_req_o.re <= 1'b1;
                flash_req_o.addr <= full_addr;
            end
        end
    end

    // control register: hardware set of the enabled flag wins over a software clear
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ctrl <= CTRL_RESET;
            unl_cnt <= '0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl[CTRL_MODE_MSB:CTRL_MODE_LSB] <= reg_wdata_i[CTRL_MODE_MSB:CTRL_MODE_LSB];
                ctrl[CTRL_RDEN_BIT] <= reg_wdata_i[CTRL_RDEN_BIT];
                ctrl[CTRL_WRITE_BIT] <= ctrl[CTRL_WRITE_BIT] | reg_wdata_i[CTRL_WRITE_BIT];
                ctrl[CTRL_READ_BIT] <= ctrl[CTRL_READ_BIT] | reg_wdata_i[CTRL_READ_BIT];
                if (!reg_wdata_i[CTRL_ENABLED_BIT])
                begin
                    ctrl[CTRL_ENABLED_BIT] <= 1'b0;
                end
                if (reg_wdata_i[CTRL_TRIGGER_BIT] && !unlock_live
                    && (reg_wdata_i[CTRL_MODE_MSB:CTRL_MODE_LSB] == MODE_UNLOCK))
                begin
                    ctrl[CTRL_TRIGGER_BIT] <= 1'b1;
                    unl_cnt <= UNL_W'(UNLOCK_CYCLES - 1);
                end
            end
            if (done_write)
            begin
                ctrl[CTRL_WRITE_BIT] <= 1'b0;
            end
            if (done_read)
            begin
                ctrl[CTRL_READ_BIT] <= 1'b0;
            end
            if (unlock_live)
            begin
                unl_cnt <= unl_cnt - UNL_W'(1);
                if (unl_cnt == '0)
                begin
                    ctrl[CTRL_TRIGGER_BIT] <= 1'b0;
                end
            end
            if (unlock_hit)
            begin
                ctrl[CTRL_ENABLED_BIT] <= 1'b1;
            end
        end
    end

    // unlock pattern registers, cleared when a new attempt starts so old bytes cannot match
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            for (int i = 0; i < 6; i++)
            begin
                pat[i] <= 8'hFF;
            end
        end
        else if (wr_ctrl && reg_wdata_i[CTRL_TRIGGER_BIT] && !unlock_live)
        begin
            for (int i = 0; i < 6; i++)
            begin
                pat[i] <= 8'hFF;
            end
        end
        else if (reg_wr_i && (reg_addr_i >= REG_PAT_LO1) && (reg_addr_i <= REG_PAT_HI3))
        begin
            pat[3'(reg_addr_i - REG_PAT_LO1)] <= reg_wdata_i;
        end
    end

    // address and data pairs; a finished read lands in the data pair
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            addr_lo <= 8'h00;
            addr_hi <= 8'h00;
            word_lo <= 8'h00;
            word_hi <= 8'h00;
        end
        else
        begin
            if (reg_wr_i && (reg_addr_i == REG_ADDR_LO))
            begin
                addr_lo <= reg_wdata_i;
            end
            if (reg_wr_i && (reg_addr_i == REG_ADDR_HI))
            begin
                addr_hi <= reg_wdata_i;
            end
            if (reg_wr_i && (reg_addr_i == REG_WORD_LO))
            begin
                word_lo <= reg_wdata_i;
            end
            if (wr_word_hi)
            begin
                word_hi <= reg_wdata_i;
            end
            if ((state == FIP_READ) && (op_cnt == RD_CAPTURE))
            begin
                {word_hi, word_lo} <= flash_rdata_i;
            end
        end
    end

    // write buffer: pointer follows the low address bits, saturates at the page end
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            buf_ptr <= 5'h00;
            buf_valid <= '0;
            buf_clear <= 1'b0;
        end
        else
        begin
            // clear goes first so a word stored in the same cycle is kept
            if (buf_clear)
            begin
                buf_valid <= '0;
            end
            if (reg_wr_i && (reg_addr_i == REG_ADDR_LO))
            begin
                buf_ptr <= reg_wdata_i[4:0];
            end
            else if (wr_word_hi)
            begin
                buf_valid[buf_ptr] <= 1'b1;
                if (buf_ptr != LAST_SLOT)
                begin
                    buf_ptr <= buf_ptr + 5'h01;
                end
            end
            if (wr_buf_ctrl && reg_wdata_i[BUF_CLEAR_BIT])
            begin
                buf_clear <= 1'b1;
            end
            else
            begin
                buf_clear <= 1'b0;
            end
        end
    end

    // storage holds no reset so it maps onto plain memory
    always_ff @(posedge mclk_i)
    begin
        if (wr_word_hi)
        begin
            buf_mem[buf_ptr] <= {reg_wdata_i, word_lo};
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            reg_rdata_o <= 8'h00;
        end
        else if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                REG_CTRL: reg_rdata_o <= ctrl;
                REG_BUF_CTRL: reg_rdata_o <= {7'h00, buf_clear};
                REG_ADDR_LO: reg_rdata_o <= addr_lo;
                REG_ADDR_HI: reg_rdata_o <= addr_hi;
                REG_WORD_LO: reg_rdata_o <= word_lo;
                REG_WORD_HI: reg_rdata_o <= word_hi;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
        else
        begin
            reg_rdata_o <= 8'h00;
        end
    end

    a_erase_needs_en: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        flash_req_o.erase |-> $past(ctrl[CTRL_ENABLED_BIT]))
        else $error("erase issued while erase/write disabled");
    a_prog_needs_en: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (state == FIP_IDLE) ##1 (state == FIP_PROG) |-> $past(ctrl[CTRL_ENABLED_BIT]))
        else $error("page write started while erase/write disabled");
    a_ptr_saturate: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (buf_ptr == LAST_SLOT) && wr_word_hi |=> (buf_ptr == LAST_SLOT))
        else $error("buffer pointer moved past page end");
    a_ptr_advance: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        wr_word_hi && (buf_ptr != LAST_SLOT) && !(reg_addr_i == REG_ADDR_LO)
        |=> (buf_ptr == $past(buf_ptr) + 5'h01))
        else $error("buffer pointer did not advance on high byte");
    a_read_len: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        start_read |=> (state == FIP_READ) [*3] ##1 (state == FIP_IDLE) && !ctrl[CTRL_READ_BIT])
        else $error("read did not finish in three cycles");
    a_halt_busy: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (flash_req_o.we || flash_req_o.erase || flash_req_o.re) |-> cpu_halt_o)
        else $error("cpu not halted during operation");
    a_clear_done: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        buf_clear && !wr_word_hi && !(wr_buf_ctrl && reg_wdata_i[BUF_CLEAR_BIT])
        |=> !buf_clear && (buf_valid == '0))
        else $error("buffer clear did not complete");
    a_unlock_set: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        unlock_hit |=> ctrl[CTRL_ENABLED_BIT])
        else $error("correct pattern did not enable erase/write");
    a_rd_reserved: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        reg_rd_i && (reg_addr_i > REG_WORD_HI) |=> (reg_rdata_o == 8'h00))
        else $error("unmapped read not zero");
endmodule

// >>> dv/fip_flash_model.sv
// behavioural model of the flash array behind the programming controller
`timescale 1ns/1ns
module fip_flash_model
    import fip_pkg::*;
(
    input wire logic mclk_i,
    input wire fip_req_t req_i,
    output logic [15:0] rdata_o
);
    logic [15:0] mem [0:(1 << ADDR_W) - 1];
    int n_prog;
    int n_erase;

    initial
    begin
        n_prog = 0;
        n_erase = 0;
        rdata_o = 16'h0000;
        for (int i = 0; i < (1 << ADDR_W); i++)
            mem[i] = 16'(i) ^ 16'hA5A5;
    end

    // read data is only good the cycle after re; it toggles otherwise so a late sample shows
    always @(posedge mclk_i)
    begin
        if (req_i.re)
            rdata_o <= mem[req_i.addr];
        else
            rdata_o <= ~rdata_o;
        if (req_i.we)
        begin
            mem[req_i.addr] <= req_i.wdata;
            n_prog++;
        end
        if (req_i.erase)
        begin
            // erased cells read as zero, which is what the blank check looks for
            for (int i = 0; i < PAGE_WORDS; i++)
                mem[{req_i.addr[12:5], 5'(i)}] <= 16'h0000;
            n_erase++;
        end
    end
endmodule

// >>> dv/tb_top.sv
// self-checking testbench for the flash programming controller
`timescale 1ns/1ns
module tb_top
    import fip_pkg::*;
;
    localparam int P = 40;
    localparam logic [7:0] PAT [0:5] = '{PAT_LO1, PAT_LO2, PAT_LO3, PAT_HI1, PAT_HI2, PAT_HI3};
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [3:0] reg_addr_i;
    logic [7:0] reg_wdata_i;
    logic reg_wr_i;
    logic reg_rd_i;
    logic [7:0] reg_rdata_o;
    logic [15:0] flash_rdata_i;
    fip_req_t flash_req_o;
    logic cpu_halt_o;
    int error_cnt;
    int n_compared;
    int base;
    logic [7:0] d;
    logic [7:0] d2;

    always #5 mclk_i = ~mclk_i;

    fip_ctrl #(.PROG_CYCLES_P(P)) uut (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .flash_rdata_i(flash_rdata_i),
        .flash_req_o(flash_req_o),
        .cpu_halt_o(cpu_halt_o)
    );

    fip_flash_model flash (
        .mclk_i(mclk_i),
        .req_i(flash_req_o),
        .rdata_o(flash_rdata_i)
    );

    task automatic report_and_stop();
        if (error_cnt == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1;
        v = reg_rdata_o;
    endtask

    // halt length is counted rather than waited on, so a missing operation shows as zero
    task automatic run_op(input logic [7:0] cv, input int lo, input int hi);
        int n;
        n = 0;
        wr(REG_CTRL, cv);
        repeat (hi + 10)
        begin
            @(posedge mclk_i);
            #1;
            if (cpu_halt_o === 1'b1)
                n++;
        end
        chk(16'h0001, 16'(n >= lo && n <= hi));
        rd(REG_CTRL, d);
        chk(16'h0000, {8'h00, d & 8'h05});
    endtask

    task automatic unlock(input logic [7:0] flip);
        wr(REG_CTRL, 8'h68);
        for (int k = 0; k < 6; k++)
            wr(4'(6 + k), PAT[k] ^ (k == 5 ? flip : 8'h00));
    endtask

    initial
    begin
        error_cnt = 0;
        n_compared = 0;
        reg_addr_i = 4'h0;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        repeat (8) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        rd(REG_CTRL, d);
        chk({8'h00, CTRL_RESET}, {8'h00, d});
        wr(4'hC, 8'h5A);
        rd(4'hC, d);
        chk(16'h0000, {8'h00, d});
        rd(REG_PAT_LO1, d);
        chk(16'h0000, {8'h00, d});
        // read works with erase/write still locked
        wr(REG_ADDR_LO, 8'h23);
        wr(REG_ADDR_HI, 8'h01);
        wr(REG_CTRL, 8'h32);
        run_op(8'h33, 2, 5);
        rd(REG_WORD_LO, d);
        rd(REG_WORD_HI, d2);
        chk(16'h0123 ^ 16'hA5A5, {d2, d});
        wr(REG_CTRL, 8'h30);
        run_op(8'h31, 0, 0);
        wr(REG_CTRL, 8'h00);
        run_op(8'h04, 0, 0);
        unlock(8'h01);
        repeat (UNLOCK_CYCLES + 10) @(posedge mclk_i);
        rd(REG_CTRL, d);
        chk(16'h0000, {14'h0000, d[7], d[3]});
        unlock(8'h00);
        rd(REG_CTRL, d);
        chk(16'h0001, {15'h0000, d[7]});
        repeat (UNLOCK_CYCLES + 10) @(posedge mclk_i);
        rd(REG_CTRL, d);
        chk(16'h0080, {8'h00, d & 8'h88});
        // erase a page above page zero so the upper address bits matter
        wr(REG_ADDR_LO, 8'h40);
        wr(REG_ADDR_HI, 8'h01);
        base = flash.n_erase;
        run_op(8'h94, P - 2, P + 4);
        chk(16'(base + 1), 16'(flash.n_erase));
        for (int k = 0; k < 32; k++)
            chk(16'h0000, flash.mem[13'h140 + k]);
        chk(16'h0160 ^ 16'hA5A5, flash.mem[13'h160]);
        // load two words past the page end: the last slot must keep the final word
        wr(REG_CTRL, 8'h80);
        wr(REG_ADDR_LO, 8'h40);
        for (int k = 0; k < 34; k++)
        begin
            wr(REG_WORD_LO, 8'(k));
            wr(REG_WORD_HI, 8'h5A);
        end
        base = flash.n_prog;
        run_op(8'h84, P - 2, P + 4);
        chk(16'd32, 16'(flash.n_prog - base));
        for (int k = 0; k < 31; k++)
            chk({8'h5A, 8'(k)}, flash.mem[13'h140 + k]);
        chk(16'h5A21, flash.mem[13'h15F]);
        wr(REG_BUF_CTRL, 8'h01);
        repeat (2) @(posedge mclk_i);
        rd(REG_BUF_CTRL, d);
        chk(16'h0000, {8'h00, d});
        // rewrite of one word on the same page, no erase in between
        wr(REG_ADDR_LO, 8'h45);
        wr(REG_WORD_LO, 8'hC3);
        wr(REG_WORD_HI, 8'h3C);
        base = flash.n_prog;
        run_op(8'h84, P - 2, P + 4);
        chk(16'h0001, 16'(flash.n_prog - base));
        chk(16'h3CC3, flash.mem[13'h145]);
        wr(REG_ADDR_LO, 8'h5F);
        wr(REG_CTRL, 8'hB2);
        run_op(8'hB3, 2, 5);
        rd(REG_WORD_LO, d);
        rd(REG_WORD_HI, d2);
        chk(16'h5A21, {d2, d});
        // clearing the enabled flag must lock out a later erase
        wr(REG_CTRL, 8'h10);
        rd(REG_CTRL, d);
        chk(16'h0000, {15'h0000, d[7]});
        base = flash.n_erase;
        run_op(8'h14, 0, 0);
        chk(16'(base), 16'(flash.n_erase));
        report_and_stop();
    end

    initial
    begin
        repeat (20000) @(posedge mclk_i);
        error_cnt++;
        report_and_stop();
    end
endmodule
